//--- verilog/anfe_pkg.sv
// Constants for the angle nibble frame encoder.
// Assumes a single 250 MHz clock and a 32-bit classic Wishbone bus.
`default_nettype none
package anfe_pkg;
  // ****************************************
  // Clock and tick timing
  // ****************************************
  localparam int CLK_NS       = 4;
  localparam int TICK_BASE_NS = 1500;
  localparam int TICK_STEP_NS = 500;
  localparam logic [9:0] TICK_BASE_CYC = 10'(TICK_BASE_NS / CLK_NS);
  localparam logic [9:0] TICK_STEP_CYC = 10'(TICK_STEP_NS / CLK_NS);
  // ****************************************
  // Frame figures in ticks, CRC and angle codes
  // ****************************************
  localparam logic [8:0] SYNC_TICKS   = 9'd56;
  localparam logic [8:0] NIB_BASE     = 9'd12;
  localparam logic [8:0] END_TICKS    = 9'd12;
  localparam logic [8:0] FRAME_SS     = 9'd282;
  localparam logic [8:0] FRAME_STD    = 9'd203;
  localparam logic [2:0] LOW_SHORT    = 3'd3;
  localparam logic [2:0] LOW_LONG     = 3'd5;
  localparam logic [3:0] CRC_SEED     = 4'h5;
  localparam logic [3:0] CRC_POLY     = 4'hd;
  localparam logic [11:0] ERR_CODE    = 12'hffb;
  localparam logic [12:0] MAP_ROUND   = 13'h01ff;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_ANGBASE  = 8'h04;
  localparam logic [7:0] ADR_IDWORD1  = 8'h08;
  localparam logic [7:0] ADR_IDWORD2  = 8'h0c;
  localparam logic [7:0] ADR_STATUS   = 8'h10;
  localparam logic [13:0] CTRL_RESET  = 14'h0000;
  // Control field positions
  localparam int C_EN      = 0;
  localparam int C_SENT    = 1;
  localparam int C_SS      = 2;
  localparam int C_LOW5    = 3;
  localparam int C_PAUSE   = 4;
  localparam int C_SLOW    = 5;
  localparam int C_CNTNIB  = 6;
  localparam int C_CNTCRC  = 7;
  localparam int C_RANGE2  = 8;
  localparam int C_TICK    = 9;
  localparam int C_ADDR    = 12;
  // ****************************************
  // Frame engine states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SYNC  = 3'b001,
    ST_NIB   = 3'b010,
    ST_PAUSE = 3'b011,
    ST_ENDP  = 3'b100
  } anfe_state_type;
endpackage
`default_nettype wire

//--- verilog/anfe_top.sv
// Nibble frame encoder for a 12-bit angle on one output wire.
// Assumes angle, temperature and fault levels come from logic on i_clk,
// and that an upstream decoder turns a master trigger into i_trigger.
// ****************************************
// ****************************************
`timescale 1ns/1ps
`default_nettype none
module anfe_top (
  // Clock and reset
  input  wire  logic        i_clk,
  input  wire  logic        i_rstn,
  // Wishbone slave
  input  wire  logic        i_wb_cyc,
  input  wire  logic        i_wb_stb,
  input  wire  logic        i_wb_we,
  input  wire  logic [7:0]  i_wb_adr,
  input  wire  logic [3:0]  i_wb_sel,
  input  wire  logic [31:0] i_wb_dat,
  output logic       [31:0] o_wb_dat,
  output logic              o_wb_ack,
  // Sensor side
  input  wire  logic [11:0] i_angle,
  input  wire  logic [7:0]  i_temp,
  input  wire  logic        i_warn,
  input  wire  logic        i_error,
  input  wire  logic        i_trigger,
  // Line side
  output logic              o_line,
  output logic              o_busy
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  // Two flops so release meets timing everywhere
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rstn = rst_sync_reg;

  // ****************************************
  // Helpers
  // ****************************************
  // One CRC step per nibble, MSB first
  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] n);
    logic [3:0] r;
    logic       fb;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      fb = r[3] ^ n[i];
      r = {r[2:0], 1'b0} ^ (fb ? anfe_pkg::CRC_POLY : 4'h0);
    end
    return r;
  endfunction

  // Byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  logic [13:0] ctrl_reg;
  logic [15:0] angbase_reg;
  logic [15:0] idword1_reg;
  logic [15:0] idword2_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  anfe_pkg::anfe_state_type state_reg;
  logic [7:0]  fcnt_reg;
  logic [3:0]  msg_id_reg;
  logic [3:0]  slow_idx_reg;

  wire         req      = i_wb_cyc & i_wb_stb & ~ack_reg;
  wire         wr       = req & i_wb_we;
  wire [31:0]  mask     = lane_mask(i_wb_sel);
  wire         hit_ctrl = (i_wb_adr == anfe_pkg::ADR_CTRL);
  wire         hit_base = (i_wb_adr == anfe_pkg::ADR_ANGBASE);
  wire         hit_id1  = (i_wb_adr == anfe_pkg::ADR_IDWORD1);
  wire         hit_id2  = (i_wb_adr == anfe_pkg::ADR_IDWORD2);
  wire         hit_stat = (i_wb_adr == anfe_pkg::ADR_STATUS);
  wire [31:0]  ctrl_w   = (32'(ctrl_reg) & ~mask) | (i_wb_dat & mask);
  wire [31:0]  base_w   = (32'(angbase_reg) & ~mask) | (i_wb_dat & mask);
  wire [31:0]  id1_w    = (32'(idword1_reg) & ~mask) | (i_wb_dat & mask);
  wire [31:0]  id2_w    = (32'(idword2_reg) & ~mask) | (i_wb_dat & mask);
  wire [31:0]  stat_w   = {16'h0000, fcnt_reg, o_busy, state_reg, msg_id_reg};
  // Unmapped reads answer zero, unmapped writes are dropped
  wire [31:0]  rd_mux   = hit_ctrl ? 32'(ctrl_reg) :
                          hit_base ? 32'(angbase_reg) :
                          hit_id1  ? 32'(idword1_reg) :
                          hit_id2  ? 32'(idword2_reg) :
                          hit_stat ? stat_w : 32'h0000_0000;

  // Bus slave: ack one cycle after the request, then drop
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg    <= anfe_pkg::CTRL_RESET;
      angbase_reg <= 16'h0000;
      idword1_reg <= 16'h0000;
      idword2_reg <= 16'h0000;
      ack_reg     <= 1'b0;
      rdat_reg    <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req) rdat_reg <= rd_mux;
      if (wr && hit_ctrl) ctrl_reg <= ctrl_w[13:0];
      if (wr && hit_base) angbase_reg <= base_w[15:0];
      if (wr && hit_id1) idword1_reg <= id1_w[15:0];
      if (wr && hit_id2) idword2_reg <= id2_w[15:0];
    end
  end
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  // ****************************************
  // Frame configuration
  // ****************************************
  logic [13:0] cfg_reg;
  wire         start;
  // Config is frozen per frame; writes mid-frame take effect next frame
  wire c_sent   = cfg_reg[anfe_pkg::C_SENT];
  wire c_ss     = cfg_reg[anfe_pkg::C_SS];
  wire c_pause  = cfg_reg[anfe_pkg::C_PAUSE];
  wire [1:0] c_tick = cfg_reg[anfe_pkg::C_TICK +: 2];
  // Live copies used while the frame contents are built
  wire n_sent   = ctrl_reg[anfe_pkg::C_SENT];
  wire n_ss     = ctrl_reg[anfe_pkg::C_SS];
  wire n_slow   = ctrl_reg[anfe_pkg::C_SLOW];
  wire n_cntcrc = ctrl_reg[anfe_pkg::C_CNTCRC];
  wire n_cntnib = ctrl_reg[anfe_pkg::C_CNTNIB] & ~n_cntcrc;
  wire n_range2 = ctrl_reg[anfe_pkg::C_RANGE2];
  wire [1:0] n_addr = ctrl_reg[anfe_pkg::C_ADDR +: 2];

  // ****************************************
  // Fault flags
  // ****************************************
  logic warn_pend_reg;
  logic err_pend_reg;
  logic first_reg;
  // A fault shows while present and at least once
  wire warn_show = i_warn | warn_pend_reg;
  wire err_show  = i_error | err_pend_reg;
  // New fault beats the clear at frame start
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      warn_pend_reg <= 1'b0;
      err_pend_reg  <= 1'b0;
      first_reg     <= 1'b1;
    end else begin
      warn_pend_reg <= i_warn | (warn_pend_reg & ~start);
      err_pend_reg  <= i_error | (err_pend_reg & ~start);
      if (start) first_reg <= 1'b0;
    end
  end

  // ****************************************
  // Slow channel message
  // ****************************************
  logic [15:0] slow_msg_reg;
  // IDs 8 to 15 reuse the lower three bits
  wire [7:0] msg_data = (msg_id_reg[2:0] == 3'd1) ? angbase_reg[15:8] :
                        (msg_id_reg[2:0] == 3'd2) ? angbase_reg[7:0] :
                        (msg_id_reg[2:0] == 3'd4) ? idword1_reg[15:8] :
                        (msg_id_reg[2:0] == 3'd5) ? idword1_reg[7:0] :
                        (msg_id_reg[2:0] == 3'd6) ? idword2_reg[15:8] :
                        (msg_id_reg[2:0] == 3'd7) ? idword2_reg[7:0] :
                        i_temp;
  wire [3:0] msg_crc  = crc_step(crc_step(crc_step(anfe_pkg::CRC_SEED,
                        msg_id_reg), msg_data[7:4]), msg_data[3:0]);
  wire [15:0] new_msg = {msg_id_reg, msg_data, msg_crc};
  wire [15:0] cur_msg = (slow_idx_reg == 4'h0) ? new_msg : slow_msg_reg;
  wire        slow_dat = cur_msg[4'hf - slow_idx_reg];
  wire        slow_sta = (slow_idx_reg == 4'h0);

  // One message bit per frame, ID advances per message
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      slow_msg_reg <= 16'h0000;
      slow_idx_reg <= 4'h0;
      msg_id_reg   <= 4'h0;
    end else if (start && n_slow) begin
      slow_idx_reg <= slow_idx_reg + 4'h1;
      if (slow_idx_reg == 4'h0) begin
        slow_msg_reg <= new_msg;
        msg_id_reg   <= msg_id_reg + 4'h1;
      end
    end
  end

  // ****************************************
  // Frame contents
  // ****************************************
  // Range two trims 0..4095 onto 1..4088
  wire [12:0] map_sum = {1'b0, i_angle} + anfe_pkg::MAP_ROUND;
  wire [11:0] mapped  = i_angle - {8'h00, map_sum[12:9]} + 12'h001;
  wire [11:0] sent_d  = !n_range2 ? i_angle :
                        (err_show ? anfe_pkg::ERR_CODE : mapped);
  wire [11:0] dat     = n_sent ? sent_d : i_angle;
  wire [3:0]  d1      = dat[11:8];
  wire [3:0]  d2      = dat[7:4];
  wire [3:0]  d3      = dat[3:0];
  wire [3:0]  ch      = fcnt_reg[7:4];
  wire [3:0]  cl      = fcnt_reg[3:0];
  wire [3:0]  cn      = fcnt_reg[3:0];
  // Status nibble per protocol
  wire [1:0]  trig_lo = n_slow ? {slow_sta, slow_dat} : n_addr;
  wire [3:0]  st_trig = {err_show | first_reg, warn_show, trig_lo};
  wire [3:0]  st_sent = {n_slow & slow_sta, n_slow & slow_dat, 1'b0,
                         err_show | first_reg};
  wire [3:0]  st      = n_sent ? st_sent : st_trig;
  // SENT CRC over data nibbles, plus counter and inverted nibble when secure
  wire [3:0]  sc3     = crc_step(crc_step(crc_step(anfe_pkg::CRC_SEED, d1), d2), d3);
  wire [3:0]  sc_ss   = crc_step(crc_step(crc_step(sc3, ch), cl), ~d1);
  wire [3:0]  sent_crc = n_ss ? sc_ss : sc3;
  // Triggered CRC starts with status
  wire [3:0]  tc4     = crc_step(crc_step(crc_step(crc_step(anfe_pkg::CRC_SEED,
                        st), d1), d2), d3);
  wire [3:0]  tc5     = n_cntnib ? crc_step(tc4, cn) : tc4;
  wire [3:0]  extra   = {n_cntcrc ? fcnt_reg[1:0] : 2'b00,
                         n_slow ? n_addr : 2'b00};
  wire [3:0]  trig_crc = (n_slow | n_cntcrc) ? crc_step(tc5, extra) : tc5;
  wire [3:0]  crc     = n_sent ? sent_crc : trig_crc;
  // Nibble slots: SENT secure carries counter and inverted nibble
  wire [3:0]  n4      = n_sent ? (n_ss ? ch : crc) : (n_cntnib ? cn : crc);
  wire [3:0]  n5      = crc;
  wire [31:0] nibs    = {crc, ~d1, (n_sent && n_ss) ? cl : n5, n4, d3, d2, d1, st};
  wire [2:0]  last    = n_sent ? (n_ss ? 3'd7 : 3'd4) : (n_cntnib ? 3'd5 : 3'd4);

  // ****************************************
  // Tick divider
  // ****************************************
  logic [9:0] div_reg;
  wire  [9:0] tick_cyc = anfe_pkg::TICK_BASE_CYC + 10'(c_tick) * anfe_pkg::TICK_STEP_CYC;
  wire        tick = (state_reg != anfe_pkg::ST_IDLE) && (div_reg == tick_cyc - 10'd1);
  // Divider restarts with each frame so the first tick is full length
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) div_reg <= 10'd0;
    else if (start || tick) div_reg <= 10'd0;
    else div_reg <= div_reg + 10'd1;
  end

  // ****************************************
  // Frame engine
  // ****************************************
  logic [31:0] fnib_reg;
  logic [2:0]  flast_reg;
  logic [2:0]  idx_reg;
  logic [8:0]  tcnt_reg;
  logic [8:0]  elap_reg;
  anfe_pkg::anfe_state_type state_next;
  logic [2:0]  idx_next;
  logic        sym_end;
  logic        frame_done;

  // SENT runs back to back; triggered waits for the controller
  assign start = (state_reg == anfe_pkg::ST_IDLE) && ctrl_reg[anfe_pkg::C_EN] &&
                 (n_sent || i_trigger);
  wire [3:0] cur_nib  = fnib_reg[{idx_reg, 2'b00} +: 4];
  wire [8:0] target   = c_ss ? anfe_pkg::FRAME_SS : anfe_pkg::FRAME_STD;
  wire [8:0] sym_len  = (state_reg == anfe_pkg::ST_SYNC)  ? anfe_pkg::SYNC_TICKS :
                        (state_reg == anfe_pkg::ST_NIB)   ? anfe_pkg::NIB_BASE + 9'(cur_nib) :
                        (state_reg == anfe_pkg::ST_PAUSE) ? target - elap_reg + tcnt_reg :
                        anfe_pkg::END_TICKS;
  wire [2:0] low_t    = cfg_reg[anfe_pkg::C_LOW5] ? anfe_pkg::LOW_LONG :
                        anfe_pkg::LOW_SHORT;
  wire       line_low = (state_reg != anfe_pkg::ST_IDLE) && (tcnt_reg < 9'(low_t));

  // Symbol sequencing
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    frame_done = 1'b0;
    sym_end    = tick && (tcnt_reg == sym_len - 9'd1);
    case (state_reg)
      anfe_pkg::ST_IDLE: begin
        if (start) state_next = n_sent ? anfe_pkg::ST_SYNC : anfe_pkg::ST_NIB;
        idx_next = 3'd0;
      end
      anfe_pkg::ST_SYNC: begin
        if (sym_end) state_next = anfe_pkg::ST_NIB;
      end
      anfe_pkg::ST_NIB: begin
        if (sym_end) begin
          if (idx_reg != flast_reg) begin
            idx_next = idx_reg + 3'd1;
          end else if (!c_sent) begin
            state_next = anfe_pkg::ST_ENDP;
          end else if (c_pause) begin
            state_next = anfe_pkg::ST_PAUSE;
          end else begin
            state_next = anfe_pkg::ST_IDLE;
            frame_done = 1'b1;
          end
        end
      end
      default: begin
        if (sym_end) begin
          state_next = anfe_pkg::ST_IDLE;
          frame_done = 1'b1;
        end
      end
    endcase
  end

  // Frame state and contents latch
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= anfe_pkg::ST_IDLE;
      idx_reg   <= 3'd0;
      cfg_reg   <= anfe_pkg::CTRL_RESET;
      fnib_reg  <= 32'h0000_0000;
      flast_reg <= 3'd0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      if (start) begin
        cfg_reg   <= ctrl_reg;
        fnib_reg  <= nibs;
        flast_reg <= last;
      end
    end
  end

  // Tick counts within a symbol and within the frame
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      tcnt_reg <= 9'd0;
      elap_reg <= 9'd0;
    end else if (start) begin
      tcnt_reg <= 9'd0;
      elap_reg <= 9'd0;
    end else if (tick) begin
      tcnt_reg <= sym_end ? 9'd0 : tcnt_reg + 9'd1;
      elap_reg <= elap_reg + 9'd1;
    end
  end

  // Counter wraps; triggered protocol reads its low bits
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) fcnt_reg <= 8'h00;
    else if (frame_done) fcnt_reg <= fcnt_reg + 8'h01;
  end

  // Line driver flop, high when released
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) o_line <= 1'b1;
    else o_line <= ~line_low;
  end
  assign o_busy = (state_reg != anfe_pkg::ST_IDLE);
endmodule
`default_nettype wire

//--- bench/anfe_properties.sv
// Port checks for the nibble frame encoder.
// Assumes one clock domain; bound to the top module by the bench.
`timescale 1ns/1ps
`default_nettype none
module anfe_properties (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // Bus
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // Line
  input wire logic        o_line,
  input wire logic        o_busy
);
  // ****************************************
  // Helper counters
  // ****************************************
  logic [15:0] lo_cnt_reg;
  logic [15:0] hi_cnt_reg;
  // High count saturates, so the first frame after reset is never judged short
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lo_cnt_reg <= 16'h0000;
      hi_cnt_reg <= 16'hffff;
    end else begin
      lo_cnt_reg <= o_line ? 16'h0000 : lo_cnt_reg + 16'h0001;
      hi_cnt_reg <= !o_line ? 16'h0000 : hi_cnt_reg + {15'h0000, ~&hi_cnt_reg};
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_frame_start;
    $rose(o_busy);
  endsequence
  a_ack_follows_req: assert property (s_req |=> o_wb_ack)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_unmapped_zero: assert property (s_req ##0 (!i_wb_we && i_wb_adr > 8'h10)
    |=> o_wb_dat == 32'h0) else $error("unmapped read not zero");
  a_idle_line_high: assert property (!o_busy |-> o_line)
    else $error("line low outside a frame");
  a_start_drops: assert property (s_frame_start |=> $fell(o_line))
    else $error("frame start without falling line");
  a_low_ticks: assert property ($rose(o_line) |->
    lo_cnt_reg inside {1125, 1500, 1875, 2250, 2500, 3125, 3750})
    else $error("low portion not three or five ticks");
  a_high_min: assert property ($fell(o_line) |-> hi_cnt_reg >= 16'd2625)
    else $error("symbol shorter than twelve ticks");
endmodule
`default_nettype wire

//--- bench/anfe_ecu_model.sv
// Controller model: issues trigger pulses and times symbols on the line.
// Assumes the line is a plain registered level on the same clock.
`timescale 1ns/1ps
`default_nettype none
module anfe_ecu_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Line and trigger request
  input  wire logic        i_line,
  input  wire logic        i_fire,
  output logic             o_trigger,
  // Measured symbol, in cycles between falling edges
  output logic             o_sym_stb,
  output logic [15:0]      o_sym_cyc,
  output logic [15:0]      o_low_cyc
);
  logic        prev_reg;
  logic        seen_reg;
  logic [15:0] cnt_reg;
  logic [15:0] low_reg;
  wire  logic  fall;
  assign fall = prev_reg && !i_line;
  // Each fall closes the symbol that the previous fall opened
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {prev_reg, seen_reg, o_trigger, o_sym_stb} <= 4'h8;
      {cnt_reg, low_reg, o_sym_cyc, o_low_cyc} <= 64'h0;
    end else begin
      prev_reg  <= i_line;
      o_trigger <= i_fire && i_line;
      o_sym_stb <= fall && seen_reg;
      if (fall) begin
        seen_reg  <= 1'b1;
        o_sym_cyc <= cnt_reg;
        o_low_cyc <= low_reg;
        cnt_reg   <= 16'h0001;
        low_reg   <= 16'h0001;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
        low_reg <= low_reg + {15'h0000, !i_line};
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/angle_nibble_frame_encoder_tb_top.sv
// Self-checking bench for the nibble frame encoder.
// Assumes the controller model file and the port checker bound below.
`timescale 1ns/1ps
`default_nettype none
module angle_nibble_frame_encoder_tb_top;
  // ****************************************
  // Signals and rows
  // ****************************************
  localparam int T = 375;
  logic        clk, rstn, cyc, stb, we, ack, line, busy, fire, trig, sstb, warn;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, q;
  logic [11:0] angle;
  logic [15:0] scyc, slow;
  logic [15:0] sym_q[$], low_q[$];
  int          exp_q[$];
  int          error_cnt = 0;
  int          n_compared = 0;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;} anfe_row_type;
  anfe_row_type rows[7] = '{
    '{anfe_pkg::ADR_ANGBASE, 32'h1234abcd, 4'hf, 32'h0000abcd},
    '{anfe_pkg::ADR_IDWORD1, 32'h0000ffff, 4'h1, 32'h000000ff},
    '{anfe_pkg::ADR_IDWORD2, 32'h00005a5a, 4'h2, 32'h00005a00},
    '{anfe_pkg::ADR_CTRL, 32'h00003700, 4'h2, 32'h00003700},
    '{anfe_pkg::ADR_STATUS, 32'h0000ffff, 4'hf, 32'h00000000},
    '{8'h20, 32'hffffffff, 4'hf, 32'h00000000},
    '{anfe_pkg::ADR_CTRL, 32'h00000000, 4'hf, 32'h00000000}};
  anfe_top anfe_top_inst (.i_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_angle(angle), .i_temp(8'h00), .i_warn(warn), .i_error(1'b0),
    .i_trigger(trig), .o_line(line), .o_busy(busy));
  anfe_ecu_model anfe_ecu_model_inst (.i_clk(clk), .i_rstn(rstn), .i_line(line),
    .i_fire(fire), .o_trigger(trig), .o_sym_stb(sstb), .o_sym_cyc(scyc), .o_low_cyc(slow));
  always #2 clk = ~clk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled high, giving up after 16 cycles
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) check("bus ack", 32'h1, 32'h0);
  endtask
  function automatic logic [3:0] crc4(input logic [19:0] v, input int n);
    logic [3:0] c;
    c = 4'h5;
    for (int i = 4 * n - 1; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? 4'hd : 4'h0);
    return c;
  endfunction
  task automatic check_frame(input int off, input int lowt);
    foreach (exp_q[i]) begin
      check("symbol ticks", 32'(exp_q[i] + 12), 32'(sym_q[i + off] / T));
      check("low cycles", 32'(lowt * T), 32'(low_q[i + off]));
    end
  endtask
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Collect measured symbols from the controller model
  always @(posedge clk) begin
    if (sstb === 1'b1) begin
      sym_q.push_back(scyc);
      low_q.push_back(slow);
    end
  end
  // Hang guard, a little above the two frames of the run
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired");
    stop_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {clk, rstn, cyc, stb, we, fire, warn} = 7'h0;
    {adr, sel, dat} = 44'h0;
    angle = 12'h102;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    wb(anfe_pkg::ADR_CTRL, 1'b0, 32'h0, 4'hf);
    check("ctrl reset", 32'h0, q);
    check("line idle", 32'h1, {31'h0, line});
    $display("reset test done");
    foreach (rows[i]) begin
      wb(rows[i].a, 1'b1, rows[i].d, rows[i].s);
      wb(rows[i].a, 1'b0, 32'h0, 4'hf);
      check("register row", rows[i].e, q);
    end
    $display("register test done");
    // Trigger while disabled must not start a frame
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
    check("busy when disabled", 32'h0, {31'h0, busy});
    // Triggered frame: reset flag and address 2 in status, counter nibble, 3-tick low
    wb(anfe_pkg::ADR_CTRL, 1'b1, 32'h2041, 4'hf);
    sym_q.delete();
    low_q.delete();
    // One-cycle warning, gone before the frame starts, must still show
    exp_q = '{14, 1, 0, 2, 0, int'(crc4(20'he1020, 5))};
    warn <= 1'b1;
    @(posedge clk);
    warn <= 1'b0;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (60000) if (sym_q.size() < 6) @(posedge clk);
    check_frame(0, 3);
    repeat (6000) if (busy === 1'b1) @(posedge clk);
    wb(anfe_pkg::ADR_STATUS, 1'b0, 32'h0, 4'hf);
    check("frame counter", 32'h1, {24'h0, q[15:8]});
    $display("triggered test done");
    // Standard SENT, range two, 5-tick low: angle zero leaves as code one
    angle <= 12'h000;
    sym_q.delete();
    low_q.delete();
    wb(anfe_pkg::ADR_CTRL, 1'b1, 32'h010b, 4'hf);
    exp_q = '{44, 0, 0, 0, 1, int'(crc4(20'h00001, 3))};
    repeat (60000) if (sym_q.size() < 7) @(posedge clk);
    check_frame(1, 5);
    $display("sent test done");
    stop_test();
  end
endmodule
bind anfe_top anfe_properties anfe_properties_inst (.i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .o_line, .o_busy);
`default_nettype wire
